// ===== design/sbg_gate_seq.sv
// gate steering sequencer for two back-to-back thyristor bridges
//
// Function
// - a burst reaches one thyristor pair only while sync, firing pulse, lockout release and burst enable are high.
// - the pair that gets pulses also depends on which bridge, forward or reverse, is enabled.
// - all gating stays off for about 20 ms after power-up.
// - six gating channels each drive one pair, giving twelve gate outputs across both bridges.
// - three line-sync inputs, one per phase, give the timing reference for the firing pulses.
// - forward pairs fire in the order 1+2-, 1+3-, 2+3-, 2+1-, 3+1-, 3+2-, then repeat.
// - the reverse bridge uses the same order with its opposite-polarity devices.
// - devices always fire as one upper and one lower on different phases.
// - positive counter voltage: forward bridge motors, reverse regenerates; negative swaps them.
// - armature voltage is set by the firing instant inside each pair's bias window.
// - with negative counter voltage regen and motoring fire at the less or more negative line point.
`timescale 1ns/100ps
module sbg_gate_seq
    import sbg_pkg::*;
#(
    parameter int unsigned LOCKOUT_CYCLES = LOCKOUT_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire logic [2:0] line_sync_in,
    input wire logic [2:0] fire_in,
    input wire logic burst_en_in,
    input wire logic regen_req_in,
    input wire logic counter_voltage_neg_in,
    output logic [2:0] fwd_upper_out,
    output logic [2:0] fwd_lower_out,
    output logic [2:0] rev_upper_out,
    output logic [2:0] rev_lower_out
);

    // ----------------------------------------
    // input synchronisation
    // ----------------------------------------
    logic [SYNC_W-1:0] sync_q;
    logic [2:0] line_sync_s;
    logic [2:0] fire_s;
    logic burst_en_s;
    logic regen_s;
    logic cv_neg_s;

    sbg_sync #(
        .W(SYNC_W)
    ) u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .d_in({line_sync_in, fire_in, burst_en_in, regen_req_in, counter_voltage_neg_in}),
        .q_out(sync_q)
    );

    assign line_sync_s = sync_q[8:6];
    assign fire_s = sync_q[5:3];
    assign burst_en_s = sync_q[2];
    assign regen_s = sync_q[1];
    assign cv_neg_s = sync_q[0];

    // ----------------------------------------
    // power-up lockout
    // ----------------------------------------
    logic [LOCK_W-1:0] lock_cnt;
    logic released;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            lock_cnt <= '0;
            released <= 1'b0;
        end else if (ce_in && !released) begin
            lock_cnt <= lock_cnt + 1'b1;
            if (lock_cnt == LOCK_W'(LOCKOUT_CYCLES - 1)) begin
                released <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic ctrl_en;
    logic [3:0] burst_len;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ctrl_en <= CTRL_EN_RESET;
        end else if (ce_in && wr_in && addr_in == REG_CTRL) begin
            ctrl_en <= wdata_in[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            burst_len <= BURST_LEN_RESET;
        end else if (ce_in && wr_in && addr_in == REG_BURST) begin
            burst_len <= wdata_in[3:0];
        end
    end

    // ----------------------------------------
    // step and bridge selection
    // ----------------------------------------
    logic [2:0] step_now;
    logic bridge_fwd_now;
    logic go_now;
    logic hold;
    logic [2:0] step_l;
    logic bridge_l;
    sbg_state_t state;
    sbg_state_t next_state;

    // the forward-biased pair follows the line polarity sector
    assign step_now = sbg_step_of(line_sync_s);

    // motoring on positive counter voltage uses the forward bridge
    assign bridge_fwd_now = ~(regen_s ^ cv_neg_s);

    // firing pulse of the upper phase marks the firing instant
    assign go_now = released && ctrl_en && burst_en_s && step_now != STEP_NONE
        && |(sbg_up(step_now) & fire_s);

    assign hold = released && ctrl_en && burst_en_s && step_now == step_l
        && |(sbg_up(step_l) & fire_s);

    // ----------------------------------------
    // burst state machine
    // ----------------------------------------
    logic [TMR_W-1:0] tcnt;
    logic [3:0] pulses_left;

    always_comb begin
        next_state = state;
        unique case (state)
            SBG_LOCK: begin
                if (released) begin
                    next_state = SBG_IDLE;
                end
            end
            SBG_IDLE: begin
                if (go_now) begin
                    next_state = SBG_BURST;
                end
            end
            SBG_BURST: begin
                if (!hold) begin
                    next_state = SBG_IDLE;
                end else if (tcnt == PULSE_ON_LAST) begin
                    next_state = (pulses_left <= 4'h1) ? SBG_IDLE : SBG_GAP;
                end
            end
            SBG_GAP: begin
                if (!hold) begin
                    next_state = SBG_IDLE;
                end else if (tcnt == PULSE_OFF_LAST) begin
                    next_state = SBG_BURST;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state <= SBG_LOCK;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // pulse width timer, restarts on every state change
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            tcnt <= '0;
        end else if (ce_in) begin
            tcnt <= (next_state != state) ? '0 : tcnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pulses_left <= '0;
        end else if (ce_in) begin
            if (state == SBG_IDLE && go_now) begin
                pulses_left <= burst_len;
            end else if (state == SBG_BURST && next_state != SBG_BURST) begin
                pulses_left <= pulses_left - 1'b1;
            end
        end
    end

    // pair and bridge held for the whole burst
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            step_l <= STEP_NONE;
            bridge_l <= 1'b1;
        end else if (ce_in && state == SBG_IDLE && go_now) begin
            step_l <= step_now;
            bridge_l <= bridge_fwd_now;
        end
    end

    // ----------------------------------------
    // gate outputs
    // ----------------------------------------
    logic gate_on;

    assign gate_on = state == SBG_BURST && hold;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            fwd_upper_out <= '0;
            fwd_lower_out <= '0;
            rev_upper_out <= '0;
            rev_lower_out <= '0;
        end else if (ce_in) begin
            // one upper and one lower device per channel
            fwd_upper_out <= (gate_on && bridge_l) ? sbg_up(step_l) : 3'h0;
            fwd_lower_out <= (gate_on && bridge_l) ? sbg_lo(step_l) : 3'h0;
            // reverse bridge devices face the other way
            rev_upper_out <= (gate_on && !bridge_l) ? sbg_lo(step_l) : 3'h0;
            rev_lower_out <= (gate_on && !bridge_l) ? sbg_up(step_l) : 3'h0;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [DATA_W-1:0] status;

    always_comb begin
        status = '0;
        status[STAT_REL_BIT] = released;
        status[STAT_ACT_BIT] = state == SBG_BURST;
        status[STAT_FWD_BIT] = bridge_l;
        status[STAT_STEP_LSB +: 3] = step_now;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else if (ce_in) begin
            if (rd_in) begin
                case (addr_in)
                    REG_CTRL: rdata_out <= {{(DATA_W-1){1'b0}}, ctrl_en};
                    REG_STAT: rdata_out <= status;
                    REG_BURST: rdata_out <= {4'h0, burst_len};
                    default: rdata_out <= '0;
                endcase
            end else begin
                rdata_out <= '0;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic [5:0] all_gates;

    assign all_gates = {fwd_upper_out | rev_upper_out, fwd_lower_out | rev_lower_out};

    chk_lockout_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && !released |=> all_gates == 6'h00)
        else $error("gate active during power-up lockout");

    chk_lockout_count: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(released) |-> $past(lock_cnt) == LOCK_W'(LOCKOUT_CYCLES - 1))
        else $error("lockout released at wrong count");

    chk_burst_cause: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && (all_gates != 6'h00) |-> $past(released && ctrl_en && burst_en_s && (fire_s != 3'h0)))
        else $error("gate pulse without all enables");

    chk_pair_shape: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (all_gates != 6'h00) |-> $onehot(all_gates[5:3]) && $onehot(all_gates[2:0])
        && (all_gates[5:3] & all_gates[2:0]) == 3'h0)
        else $error("gates not one upper and one lower on different phases");

    chk_one_bridge: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !((fwd_upper_out != 3'h0) && (rev_upper_out != 3'h0)))
        else $error("both bridges gated together");

    chk_bridge_sel: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && state == SBG_IDLE && go_now ##1 ce_in && state == SBG_BURST && hold
        |=> (fwd_upper_out != 3'h0) == $past(regen_s == cv_neg_s, 2))
        else $error("wrong bridge for drive quadrant");

    chk_step_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && gate_on && bridge_l && step_l == 3'h0 |=> fwd_upper_out == 3'h1 && fwd_lower_out == 3'h2)
        else $error("step zero pair wrong");

    chk_rev_mirror: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && gate_on && !bridge_l && step_l == 3'h3 |=> rev_upper_out == 3'h1 && rev_lower_out == 3'h2)
        else $error("reverse pair polarity wrong");

    chk_pulse_width: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && state == SBG_BURST && hold && tcnt == PULSE_ON_LAST && pulses_left > 4'h1
        |=> state == SBG_GAP)
        else $error("pulse did not end at its width");

    chk_ce_freeze: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !ce_in |=> $stable(all_gates) && $stable(state) && $stable(lock_cnt))
        else $error("state moved while clock enable low");

    chk_invalid_sync: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && step_now == STEP_NONE |=> all_gates == 6'h00)
        else $error("gate pulse on invalid sync pattern");

    chk_step_four: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && gate_on && bridge_l && step_l == 3'h4 |=> fwd_upper_out == 3'h4 && fwd_lower_out == 3'h1)
        else $error("step four pair wrong");

    chk_sync_delay: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $past(ce_in) && $past(ce_in, 2) && $past(rst_n_in) && $past(rst_n_in, 2)
        |-> line_sync_s == $past(line_sync_in, 2) && fire_s == $past(fire_in, 2))
        else $error("synchroniser latency wrong");

    chk_abort_fast: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && state == SBG_BURST && !burst_en_s |=> all_gates == 6'h00)
        else $error("gate pulse after burst enable dropped");

    chk_gap_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && state == SBG_GAP |=> all_gates == 6'h00)
        else $error("gate pulse during burst gap");

    cov_fwd_burst: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        fwd_upper_out != 3'h0);
    cov_rev_burst: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        rev_upper_out != 3'h0);
    cov_abort: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        state == SBG_BURST && !hold && ce_in);
    cov_gap_reburst: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        state == SBG_GAP && next_state == SBG_BURST && ce_in);
    cov_freeze: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        !ce_in && all_gates != 6'h00);

endmodule

// ===== design/sbg_pkg.sv
// constants, types and decode functions for the thyristor gate sequencer
package sbg_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int LOCKOUT_NS = 20000000;
    localparam int LOCKOUT_CYC = (LOCKOUT_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOCK_W = 20;
    localparam int PULSE_ON_NS = 5000;
    localparam int PULSE_ON_CYC = (PULSE_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_OFF_NS = 5000;
    localparam int PULSE_OFF_CYC = (PULSE_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] PULSE_ON_LAST = TMR_W'(PULSE_ON_CYC - 1);
    localparam logic [TMR_W-1:0] PULSE_OFF_LAST = TMR_W'(PULSE_OFF_CYC - 1);

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] REG_BURST = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b0;
    localparam int STAT_REL_BIT = 0;
    localparam int STAT_ACT_BIT = 1;
    localparam int STAT_FWD_BIT = 2;
    localparam int STAT_STEP_LSB = 3;
    localparam logic [3:0] BURST_LEN_RESET = 4'h8;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    localparam logic [2:0] STEP_NONE = 3'h7;
    localparam int SYNC_W = 9;

    typedef enum logic [1:0] {
        SBG_LOCK = 2'b00,
        SBG_IDLE = 2'b01,
        SBG_BURST = 2'b10,
        SBG_GAP = 2'b11
    } sbg_state_t;

    // line-sync polarity pattern to firing step
    function automatic logic [2:0] sbg_step_of(input logic [2:0] s);
        case (s)
            3'h5: sbg_step_of = 3'h0;
            3'h1: sbg_step_of = 3'h1;
            3'h3: sbg_step_of = 3'h2;
            3'h2: sbg_step_of = 3'h3;
            3'h6: sbg_step_of = 3'h4;
            3'h4: sbg_step_of = 3'h5;
            default: sbg_step_of = STEP_NONE;
        endcase
    endfunction

    // upper device phase of a step, one-hot
    function automatic logic [2:0] sbg_up(input logic [2:0] st);
        case (st)
            3'h0, 3'h1: sbg_up = 3'h1;
            3'h2, 3'h3: sbg_up = 3'h2;
            3'h4, 3'h5: sbg_up = 3'h4;
            default: sbg_up = 3'h0;
        endcase
    endfunction

    // lower device phase of a step, one-hot
    function automatic logic [2:0] sbg_lo(input logic [2:0] st);
        case (st)
            3'h0, 3'h5: sbg_lo = 3'h2;
            3'h1, 3'h2: sbg_lo = 3'h4;
            3'h3, 3'h4: sbg_lo = 3'h1;
            default: sbg_lo = 3'h0;
        endcase
    endfunction

endpackage

// ===== design/sbg_sync.sv
// two-stage input synchroniser for pin inputs
`timescale 1ns/100ps
module sbg_sync #(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// ===== sim/sbg_line_model.sv
// analogue phase control model: line-sync sector pattern and timing-ramp firing pulse
`timescale 1ns/100ps
module sbg_line_model (
    input wire logic mclk_in,
    input wire logic [2:0] sector_in,
    input wire logic [7:0] delay_in,
    output logic [2:0] line_sync_out,
    output logic [2:0] fire_out
);
    logic [7:0] age = 8'h00;
    logic [2:0] up;
    initial line_sync_out = 3'h0;

    // ----------------------------------------
    // sector age, restarts on every sync change
    // ----------------------------------------
    always @(posedge mclk_in) begin
        if (line_sync_out !== sector_in) begin
            age <= 8'h00;
        end else if (age != 8'hff) begin
            age <= age + 8'h01;
        end
        line_sync_out <= sector_in;
    end

    // ----------------------------------------
    // ramp fires only the upper phase of the pair, after the firing delay
    // ----------------------------------------
    always_comb begin
        case (line_sync_out)
            3'h5, 3'h1: up = 3'h1;
            3'h3, 3'h2: up = 3'h2;
            3'h6, 3'h4: up = 3'h4;
            default: up = 3'h0;
        endcase
    end
    assign fire_out = (age >= delay_in) ? up : 3'h0;
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the gate sequencer
`timescale 1ns/100ps
module tb_top;
    import sbg_pkg::*;
    localparam int LOCK = 16;
    localparam logic [2:0] UPS [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0] LOS [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    localparam logic [2:0] PATS [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = 4'h0;
    logic [DATA_W-1:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic ce_in = 1'b1;
    logic burst_en_in = 1'b1;
    logic regen_req_in = 1'b0;
    logic counter_voltage_neg_in = 1'b0;
    logic [2:0] sector = 3'h5;
    logic [7:0] delay = 8'h04;
    logic [DATA_W-1:0] rdata_out;
    logic [2:0] line_sync_in, fire_in, fu, fl, ru, rl;
    logic [11:0] gates;
    int err_count = 0;
    int checked = 0;
    int seed = 87;
    int cyc = 0;

    assign gates = {fu, fl, ru, rl};
    initial forever #25 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (rst_n_in) cyc <= cyc + 1;

    sbg_gate_seq #(.LOCKOUT_CYCLES(LOCK)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .line_sync_in(line_sync_in), .fire_in(fire_in), .burst_en_in(burst_en_in),
        .regen_req_in(regen_req_in), .counter_voltage_neg_in(counter_voltage_neg_in),
        .fwd_upper_out(fu), .fwd_lower_out(fl), .rev_upper_out(ru), .rev_lower_out(rl));
    sbg_line_model u_line (.mclk_in(mclk_in), .sector_in(sector), .delay_in(delay),
        .line_sync_out(line_sync_in), .fire_out(fire_in));

    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [2:0] step_of(input logic [2:0] p);
        for (int i = 0; i < 6; i++) begin
            if (PATS[i] == p) return 3'(i);
        end
        return 3'h7;
    endfunction

    function automatic logic [11:0] exp_gates(input logic [2:0] p, input logic fwd);
        logic [2:0] s;
        s = step_of(p);
        if (fwd) return {UPS[s], LOS[s], 6'h00};
        return {6'h00, LOS[s], UPS[s]};
    endfunction

    // ----------------------------------------
    // bench tasks
    // ----------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    task automatic wait_gates(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (gates === 12'h000 && n < lim);
    endtask

    task automatic run_case(input logic [2:0] p, input logic rg, input logic cn, input bit ab);
        logic [DATA_W-1:0] d;
        int n;
        @(posedge mclk_in);
        burst_en_in <= 1'b0;
        sector <= p;
        regen_req_in <= rg;
        counter_voltage_neg_in <= cn;
        delay <= 8'($unsigned($random(seed)) % 40);
        repeat (8) @(posedge mclk_in);
        rd(REG_STAT, d);
        check("stat_step", 32'(d[5:3]), 32'(step_of(p)));
        @(posedge mclk_in);
        burst_en_in <= 1'b1;
        wait_gates(300);
        if (step_of(p) == 3'h7) begin
            check("refused_gates", 32'(gates), 32'h0);
        end else begin
            check("pair_gates", 32'(gates), 32'(exp_gates(p, rg == cn)));
            if (gates === 12'h000) close_out;
            n = 1;
            if (ab) begin
                repeat (10) @(posedge mclk_in);
                burst_en_in <= 1'b0;
                repeat (5) @(posedge mclk_in);
                #1;
                check("abort_gates", 32'(gates), 32'h0);
            end else begin
                do begin
                    @(posedge mclk_in);
                    #1;
                    if (gates !== 12'h000) n++;
                end while (gates !== 12'h000 && n < 300);
                check("pulse_len", 32'(n), 32'(PULSE_ON_CYC));
            end
        end
        $display("case sync %0h regen %0b neg %0b done", p, rg, cn);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [DATA_W-1:0] d;
        int n;
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(REG_CTRL, d);
        check("ctrl_reset", 32'(d), 32'h0);
        rd(REG_BURST, d);
        check("burst_reset", 32'(d), 32'h8);
        rd(4'hc, d);
        check("unmapped_read", 32'(d), 32'h0);
        rd(REG_STAT, d);
        check("stat_locked", 32'(d[STAT_REL_BIT]), 32'h0);
        wr(REG_BURST, 8'h01);
        wr(REG_CTRL, 8'h01);
        wait_gates(400);
        check("lockout_gates", 32'(gates !== 12'h000), 32'h1);
        check("lockout_len", 32'(cyc >= LOCK), 32'h1);
        rd(REG_STAT, d);
        check("stat_released", 32'(d[STAT_REL_BIT]), 32'h1);
        $display("lockout test done");
        for (int i = 0; i < 24; i++) begin
            run_case(PATS[i % 6], i / 6 % 2 == 1, i / 12 == 1, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            run_case(3'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'b0);
        end
        wr(REG_BURST, 8'h02);
        run_case(3'h1, 1'b0, 1'b0, 1'b0);
        n = 1;
        while (gates === 12'h000 && n < 300) begin
            @(posedge mclk_in);
            #1;
            if (gates === 12'h000) n++;
        end
        check("gap_len", 32'(n), 32'(PULSE_OFF_CYC));
        @(posedge mclk_in);
        ce_in <= 1'b0;
        repeat (150) @(posedge mclk_in);
        #1;
        check("freeze_gates", 32'(gates), 32'(exp_gates(3'h1, 1'b1)));
        @(posedge mclk_in);
        ce_in <= 1'b1;
        $display("gap and freeze test done");
        run_case(3'h3, 1'b1, 1'b0, 1'b1);
        close_out;
    end
endmodule
